// ### dv/ecw_host_model.sv
// Host-side model issuing AXI4-Lite register cycles to the block.
// Assumes the bench top tb_ecw_top offers a timeout task.
`timescale 1ns/1ns
`default_nettype none
module ecw_host_model (
   input wire logic clk,
   output var logic [7:0] s_axi_awaddr,
   output var logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output var logic [31:0] s_axi_wdata,
   output var logic [3:0] s_axi_wstrb,
   output var logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output var logic s_axi_bready,
   output var logic [7:0] s_axi_araddr,
   output var logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output var logic s_axi_rready
);
   initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
   initial {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   // ==========
   // Each channel is held until its own ready; the answer ends the cycle.
   task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 1'b0;
      r = 2'bxx;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int i = 0; i < 64 && !done; i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) tb_ecw_top.timeout();
   endtask
   task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 1'b0;
      r = 2'bxx;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int i = 0; i < 64 && !done; i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) tb_ecw_top.timeout();
   endtask
endmodule // ecw_host_model
`default_nettype wire

// ### dv/ecw_top_properties.sv
// Port-level assertions for the event capture and watchdog block.
// Assumes it is bound to ecw_top, one clock and an active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ecw_top_properties
   import ecw_pkg::*;
#(parameter int SAMPLE_CYCLES = ecw_pkg::SAMPLE_CYC, parameter int WDOG_CYCLES = ecw_pkg::WDOG_CYC_DEF) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [ecw_pkg::NCH-1:0] chan_in,
   input wire logic [3:0] switch_closed,
   input wire logic led_buf_full,
   input wire logic irq
);
   // ==========
   // Ages since the last write and since the last pat or enable.
   wire logic aw_hs = s_axi_awvalid && s_axi_awready;
   wire logic pat_hs = aw_hs && (s_axi_awaddr == A_PAT || s_axi_awaddr == A_CTRL);
   logic [31:0] wr_age_reg;
   logic [31:0] pat_age_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_age_reg <= 32'h0;
         pat_age_reg <= 32'h0;
      end else begin
         wr_age_reg <= aw_hs ? 32'h0 : wr_age_reg + {31'h0, ~&wr_age_reg};
         pat_age_reg <= pat_hs ? 32'h0 : pat_age_reg + {31'h0, ~&pat_age_reg};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Properties.
   property p_out_by_write;
      $changed(switch_closed[2:0]) |-> wr_age_reg < 32'd8;
   endproperty
   a_out_by_write: assert property (p_out_by_write) else $error("Output switch moved without a write.");
   property p_wdog_rise;
      $rose(switch_closed[3]) |-> wr_age_reg < 32'd8;
   endproperty
   a_wdog_rise: assert property (p_wdog_rise) else $error("Channel 32 closed without a write.");
   property p_wdog_fall;
      $fell(switch_closed[3]) && wr_age_reg >= 32'd8 |-> pat_age_reg >= 32'(WDOG_CYCLES - 4);
   endproperty
   a_wdog_fall: assert property (p_wdog_fall) else $error("Watchdog opened before its timeout.");
   property p_led_fall;
      $fell(led_buf_full) |-> wr_age_reg < 32'd8;
   endproperty
   a_led_fall: assert property (p_led_fall) else $error("Full light went out without a pop.");
   property p_irq_fall;
      $fell(irq) |-> wr_age_reg < 32'd8;
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("Interrupt dropped without a write.");
   property p_b_lat;
      aw_hs && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("Write response late.");
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("Read response late.");
   property p_slverr;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > A_IEN |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_slverr: assert property (p_slverr) else $error("Unmapped read not refused.");
   property p_aw_pulse;
      s_axi_awready |=> !s_axi_awready;
   endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("Write address ready held.");
endmodule // ecw_top_properties
bind ecw_top ecw_top_properties #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) i_ecw_top_properties (
   .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_in, .switch_closed, .led_buf_full, .irq);
`default_nettype wire

// ### dv/tb_ecw_top.sv
// Self-checking bench for the event capture and watchdog block.
// Assumes short sample and watchdog counts set through the top's parameters.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_ecw_top;
   import ecw_pkg::*;
   localparam int SC = 4;
   localparam int WD = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [NCH-1:0] chan_in = '0;
   int n_errors = 0;
   int comparisons = 0;
   logic [7:0] regs[7] = '{A_CTRL, A_OUTDIR, A_OUTVAL, A_COUNT, A_LOST, A_ISTAT, A_IEN};
   wire logic [7:0] s_axi_awaddr, s_axi_araddr;
   wire logic [31:0] s_axi_wdata, s_axi_rdata;
   wire logic [3:0] s_axi_wstrb, switch_closed;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, led_buf_full, irq;
   always #50 clk = ~clk;
   ecw_top #(.SAMPLE_CYCLES(SC), .WDOG_CYCLES(WD)) i_ecw_top (
      .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_in, .switch_closed, .led_buf_full, .irq);
   ecw_host_model i_ecw_host_model (
      .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // ==========
   // Shared tasks.
   task automatic conclude();
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic timeout();
      n_errors++;
      conclude();
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      logic [1:0] r;
      i_ecw_host_model.write(a, d, r);
      `CHK("bresp", er, r)
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      logic [1:0] r;
      i_ecw_host_model.read(a, d, r);
      `CHK("rresp", er, r)
   endtask
   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      `CHK(nm, e, d)
   endtask
   function automatic logic [5:0] info(input int ch, input logic rising);
      return {rising, 5'(ch)};
   endfunction
   task automatic pop_chk(input int ch, input logic rising);
      logic [31:0] d;
      rd(A_EVINFO, d);
      `CHK("evinfo", info(ch, rising), d[5:0])
      wr(A_POP, 32'h0);
   endtask
   initial begin
      tick(100000);
      timeout();
   end
   // ==========
   // Main sequence.
   initial begin
      logic [31:0] v, d, dt, tm;
      int ev;
      v = $urandom(32'hE03F8E65);
      tick(10);
      rst_n <= 1'b1;
      foreach (regs[i]) chk_rd("reset", regs[i], 32'h0);
      rd(8'h44, d, RESP_SLVERR);
      `CHK("unmapped", 32'h0, d)
      rd(8'h02, d, RESP_SLVERR);
      wr(8'h48, 32'hFFFFFFFF, RESP_SLVERR);
      wr(A_OUTDIR, 32'hFFFFFFFF);
      chk_rd("outdir", A_OUTDIR, 32'hF);
      repeat (4) begin
         v = $urandom;
         wr(A_OUTVAL, v);
         tick(3);
         `CHK("switch", v[3:0], switch_closed)
      end
      wr(A_OUTDIR, 32'h0);
      tick(3);
      `CHK("switch_off", 4'h0, switch_closed)
      wr(A_OUTDIR, 32'h8);
      wr(A_OUTVAL, 32'h0);
      wr(A_IEN, 32'h4);
      wr(A_CTRL, 32'h1);
      tick(3);
      `CHK("wdog_on", 1'b1, switch_closed[3])
      repeat (3) begin
         tick(8);
         wr(A_PAT, $urandom);
         `CHK("wdog_pat", 1'b1, switch_closed[3])
      end
      tick(WD + 8);
      `CHK("wdog_off", 1'b0, switch_closed[3])
      `CHK("irq_wdog", 1'b1, irq)
      chk_rd("istat_wdog", A_ISTAT, 32'h4);
      wr(A_ICLR, 32'h4);
      tick(3);
      `CHK("irq_clr", 1'b0, irq)
      wr(A_CTRL, 32'h0);
      wr(A_OUTDIR, 32'h0);
      dt = $urandom;
      tm = $urandom & 32'h00FFFFFF;
      wr(A_DATE, dt);
      wr(A_TIME, tm);
      wr(A_RISE, 32'h5);
      wr(A_FALL, 32'h6);
      wr(A_IEN, 32'h1);
      chan_in <= 32'h1;
      tick(6);
      chan_in <= 32'h0;
      tick(40);
      chk_rd("glitch", A_COUNT, 32'h0);
      chan_in <= 32'h7;
      tick(6);
      chk_rd("level_early", A_LEVEL, 32'h0);
      tick(60);
      chk_rd("level", A_LEVEL, 32'h7);
      chk_rd("count", A_COUNT, 32'h2);
      rd(A_POP, d);
      `CHK("ev_date", dt, d)
      rd(A_EVTIME, d);
      `CHK("ev_time", 1'b1, (d - tm) <= 32'h1)
      pop_chk(0, 1'b1);
      pop_chk(2, 1'b1);
      chan_in <= 32'h0;
      tick(60);
      pop_chk(1, 1'b0);
      pop_chk(2, 1'b0);
      chk_rd("count_empty", A_COUNT, 32'h0);
      `CHK("irq_event", 1'b1, irq)
      wr(A_IEN, 32'h0);
      tick(3);
      `CHK("irq_mask", 1'b0, irq)
      wr(A_ICLR, 32'h7);
      wr(A_RISE, 32'hFFFFFFFF);
      wr(A_FALL, 32'hFFFFFFFF);
      wr(A_IEN, 32'h2);
      ev = 0;
      for (int i = 0; i < 40 && ev < 160; i++) begin
         v = $urandom & 32'h0FFFFFFF;
         chan_in <= chan_in ^ v;
         ev += $countones(v);
         tick(80);
      end
      chk_rd("count_full", A_COUNT, 32'd128);
      chk_rd("lost", A_LOST, 32'(ev - 128));
      `CHK("led_full", 1'b1, led_buf_full)
      `CHK("irq_full", 1'b1, irq)
      wr(A_LOST, 32'h0);
      chk_rd("lost_clr", A_LOST, 32'h0);
      wr(A_POP, 32'h0);
      tick(3);
      `CHK("led_pop", 1'b0, led_buf_full)
      chk_rd("count_pop", A_COUNT, 32'd127);
      rst_n <= 1'b0;
      tick(3);
      rst_n <= 1'b1;
      tick(2);
      `CHK("led_rst", 1'b0, led_buf_full)
      chk_rd("count_rst", A_COUNT, 32'h0);
      conclude();
   end
endmodule // tb_ecw_top
`default_nettype wire

// ### inc/ecw_mem_if.sv
// Interface between the capture logic and its event record memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface ecw_mem_if #(parameter int AW = 7, parameter int DW = 72);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport owner (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ### inc/ecw_pkg.sv
// Package of constants for the event capture and watchdog block.
// Assumes a 10 MHz clock and an AXI4-Lite register bus with 32-bit data.
`default_nettype none
package ecw_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int SAMPLE_MS = 20;
   localparam int SAMPLE_CYC = (CLK_HZ / 1000) * SAMPLE_MS;
   localparam int STABLE_SAMPLES = 4;
   localparam int WDOG_MS_DEF = 1000;
   localparam int WDOG_CYC_DEF = (CLK_HZ / 1000) * WDOG_MS_DEF;
   localparam int NCH = 32;
   localparam int OUT_FIRST = 28;
   localparam int BUF_DEPTH = 128;
   localparam int BUF_AW = 7;
   localparam int LOST_W = 16;
   localparam int TS_W = 32;
   // Register byte offsets.
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_OUTDIR = 8'h04;
   localparam logic [7:0] A_OUTVAL = 8'h08;
   localparam logic [7:0] A_PAT = 8'h0C;
   localparam logic [7:0] A_RISE = 8'h10;
   localparam logic [7:0] A_FALL = 8'h14;
   localparam logic [7:0] A_LEVEL = 8'h18;
   localparam logic [7:0] A_COUNT = 8'h1C;
   localparam logic [7:0] A_LOST = 8'h20;
   localparam logic [7:0] A_EVTIME = 8'h24;
   localparam logic [7:0] A_EVINFO = 8'h28;
   localparam logic [7:0] A_POP = 8'h2C;
   localparam logic [7:0] A_DATE = 8'h30;
   localparam logic [7:0] A_TIME = 8'h34;
   localparam logic [7:0] A_ISTAT = 8'h38;
   localparam logic [7:0] A_ICLR = 8'h3C;
   localparam logic [7:0] A_IEN = 8'h40;
   // Control field and interrupt bit positions.
   localparam int CTRL_WDOG_EN = 0;
   localparam int IRQ_EVENT = 0;
   localparam int IRQ_FULL = 1;
   localparam int IRQ_WDOG = 2;
   localparam int NIRQ = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### logic/ecw_deglitch.sv
// Per-channel input qualifier: a level is accepted after four agreeing samples.
// Assumes the sample strobe is a one-cycle pulse every sample period.
`timescale 1ns/1ns
`default_nettype none
module ecw_deglitch
   import ecw_pkg::*;
#(parameter int N = 32) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample,
   input wire logic [N-1:0] din,
   output logic [N-1:0] level,
   output logic [N-1:0] rise,
   output logic [N-1:0] fall
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_ch
         logic [2:0] cnt_reg;
         logic last_reg;
         logic lvl_reg;
         logic new_lvl;
         assign new_lvl = (cnt_reg == 3'(STABLE_SAMPLES - 1)) && (din[i] == last_reg) && (lvl_reg != din[i]);
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt_reg <= 3'h0;
               last_reg <= 1'b0;
               lvl_reg <= 1'b0;
               rise[i] <= 1'b0;
               fall[i] <= 1'b0;
            end else begin
               rise[i] <= sample && new_lvl && din[i];
               fall[i] <= sample && new_lvl && !din[i];
               if (sample) begin
                  last_reg <= din[i];
                  if (din[i] != last_reg) begin
                     cnt_reg <= 3'h1;
                  end else if (cnt_reg < 3'(STABLE_SAMPLES - 1)) begin
                     cnt_reg <= cnt_reg + 3'h1;
                  end
                  if (new_lvl) begin
                     lvl_reg <= din[i];
                  end
               end
            end
         end
         assign level[i] = lvl_reg;
      end
   endgenerate
endmodule // ecw_deglitch
`default_nettype wire

// ### logic/ecw_evmem.sv
// Event record memory with registered read data.
// Assumes one clock; read data appear the cycle after the address.
`timescale 1ns/1ns
`default_nettype none
module ecw_evmem #(parameter int AW = 7, parameter int DW = 72) (
   input wire logic clk,
   ecw_mem_if.mem m
);
   logic [DW-1:0] mem_reg [0:(1<<AW)-1];
   logic [DW-1:0] rd_reg;
   always_ff @(posedge clk) begin
      if (m.we) begin
         mem_reg[m.waddr] <= m.wdata;
      end
      rd_reg <= mem_reg[m.raddr];
   end
   assign m.rdata = rd_reg;
endmodule // ecw_evmem
`default_nettype wire

// ### logic/ecw_top.sv
// Event capture, watchdog and output control for a 32-channel digital pod.
// Assumes an AXI4-Lite master, 10 MHz clk and inputs synchronous to clk.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ecw_top
   import ecw_pkg::*;
#(
   parameter int SAMPLE_CYCLES = ecw_pkg::SAMPLE_CYC,
   parameter int WDOG_CYCLES = ecw_pkg::WDOG_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [ecw_pkg::NCH-1:0] chan_in,
   output logic [3:0] switch_closed,
   output logic led_buf_full,
   output logic irq
);
   import ecw_pkg::*;
   localparam int DW = 1 + 5 + TS_W + TS_W;

   // ==========================================================
   // Bus slave
   logic aw_have_reg, w_have_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic ctrl_wdog_reg;
   logic [3:0] outdir_reg, outval_reg;
   logic [NCH-1:0] rise_en_reg, fall_en_reg;
   logic [TS_W-1:0] date_reg, time_reg;
   logic [NIRQ-1:0] istat_reg, ien_reg;
   logic [LOST_W-1:0] lost_reg;
   logic [BUF_AW:0] count_reg;
   logic [BUF_AW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic wr_fire, rd_fire;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [31:0] wmask;

   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_reg <= A_IEN && awaddr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Writable registers; write strobes gate the byte lanes of ctrl, outdir, outval, rise, fall and ien only.
   logic wr_ctrl, wr_pat, wr_pop, wr_iclr;
   assign wr_ctrl = wr_fire && awaddr_reg == A_CTRL && wstrb_reg[0];
   assign wr_pat = wr_fire && awaddr_reg == A_PAT;
   assign wr_pop = wr_fire && awaddr_reg == A_POP;
   assign wr_iclr = wr_fire && awaddr_reg == A_ICLR;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_wdog_reg <= 1'b0;
         outdir_reg <= 4'h0;
         outval_reg <= 4'h0;
         rise_en_reg <= '0;
         fall_en_reg <= '0;
         ien_reg <= '0;
      end else if (wr_fire) begin
         case (awaddr_reg)
            A_CTRL: if (wr_ctrl) ctrl_wdog_reg <= wdata_reg[CTRL_WDOG_EN];
            A_OUTDIR: if (wstrb_reg[0]) outdir_reg <= wdata_reg[3:0];
            A_OUTVAL: if (wstrb_reg[0]) outval_reg <= wdata_reg[3:0];
            A_RISE: rise_en_reg <= (rise_en_reg & ~wmask) | (wdata_reg & wmask);
            A_FALL: fall_en_reg <= (fall_en_reg & ~wmask) | (wdata_reg & wmask);
            A_IEN: if (wstrb_reg[0]) ien_reg <= wdata_reg[NIRQ-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Date and time of day
   logic [$clog2(CLK_HZ/1000)-1:0] ms_div_reg;
   logic ms_tick;
   assign ms_tick = ms_div_reg == ($bits(ms_div_reg))'(CLK_HZ / 1000 - 1);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_div_reg <= '0;
         date_reg <= '0;
         time_reg <= '0;
      end else begin
         ms_div_reg <= ms_tick ? '0 : ms_div_reg + 1'b1;
         if (wr_fire && awaddr_reg == A_DATE) begin
            date_reg <= wdata_reg;
         end
         if (wr_fire && awaddr_reg == A_TIME) begin
            time_reg <= wdata_reg;
         end else if (ms_tick) begin
            time_reg <= time_reg + 32'h0000_0001;
         end
      end
   end

   // ==========================================================
   // Sampling
   logic [$clog2(SAMPLE_CYCLES)-1:0] samp_cnt_reg;
   logic samp_tick;
   logic [NCH-1:0] level, rise, fall;
   assign samp_tick = samp_cnt_reg == ($bits(samp_cnt_reg))'(SAMPLE_CYCLES - 1);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_cnt_reg <= '0;
      end else begin
         samp_cnt_reg <= samp_tick ? '0 : samp_cnt_reg + 1'b1;
      end
   end

   ecw_deglitch #(.N(NCH)) i_ecw_deglitch (
      .clk(clk),
      .rst_n(rst_n),
      .sample(samp_tick),
      .din(chan_in),
      .level(level),
      .rise(rise),
      .fall(fall)
   );

   // ==========================================================
   // Event capture: lowest pending channel is stored each cycle, or dropped while the buffer is full.
   logic [NCH-1:0] pend_reg;
   logic [NCH-1:0] pend_pol_reg;
   logic [NCH-1:0] new_ev;
   logic any_pend;
   logic [4:0] sel_ch;
   logic buf_full;
   logic store, drop;

   assign new_ev = (rise & rise_en_reg) | (fall & fall_en_reg);
   assign any_pend = |pend_reg;
   assign buf_full = count_reg == (BUF_AW+1)'(BUF_DEPTH);
   assign store = any_pend && !buf_full;
   assign drop = any_pend && buf_full;

   always_comb begin
      sel_ch = 5'h00;
      for (int k = NCH - 1; k >= 0; k--) begin
         if (pend_reg[k]) sel_ch = 5'(k);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= '0;
         pend_pol_reg <= '0;
      end else begin
         for (int k = 0; k < NCH; k++) begin
            if (new_ev[k]) begin
               pend_reg[k] <= 1'b1;
               pend_pol_reg[k] <= rise[k];
            end else if (any_pend && sel_ch == 5'(k)) begin
               pend_reg[k] <= 1'b0;
            end
         end
      end
   end

   ecw_mem_if #(.AW(BUF_AW), .DW(DW)) mif ();
   assign mif.we = store;
   assign mif.waddr = wr_ptr_reg;
   assign mif.wdata = {pend_pol_reg[sel_ch], sel_ch, date_reg, time_reg};
   assign mif.raddr = rd_ptr_reg;

   ecw_evmem #(.AW(BUF_AW), .DW(DW)) i_ecw_evmem (
      .clk(clk),
      .m(mif.mem)
   );

   logic pop;
   assign pop = wr_pop && count_reg != '0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         lost_reg <= '0;
      end else begin
         if (store) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg <= count_reg + (BUF_AW+1)'(store) - (BUF_AW+1)'(pop);
         if (wr_fire && awaddr_reg == A_LOST) begin
            lost_reg <= '0;
         end else if (drop && lost_reg != '1) begin
            lost_reg <= lost_reg + 1'b1;
         end
      end
   end

   // ==========================================================
   // Watchdog
   logic [$clog2(WDOG_CYCLES+1)-1:0] wd_cnt_reg;
   logic wd_out_reg, wd_en_q_reg;
   logic wd_expire;
   assign wd_expire = wd_out_reg && wd_cnt_reg == ($bits(wd_cnt_reg))'(1);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_cnt_reg <= '0;
         wd_out_reg <= 1'b0;
         wd_en_q_reg <= 1'b0;
      end else begin
         wd_en_q_reg <= ctrl_wdog_reg;
         if (!ctrl_wdog_reg) begin
            wd_out_reg <= 1'b0;
         end else if (!wd_en_q_reg || (wr_pat && wd_out_reg)) begin
            wd_out_reg <= 1'b1;
            wd_cnt_reg <= ($bits(wd_cnt_reg))'(WDOG_CYCLES);
         end else if (wd_expire) begin
            wd_out_reg <= 1'b0;
         end else if (wd_out_reg) begin
            wd_cnt_reg <= wd_cnt_reg - 1'b1;
         end
      end
   end

   // ==========================================================
   // Interrupts, outputs and read data
   logic [NIRQ-1:0] ev_set;
   assign ev_set = {wd_expire, store && count_reg == (BUF_AW+1)'(BUF_DEPTH - 1), store};

   logic [3:0] sw_next;
   assign sw_next[2:0] = outdir_reg[2:0] & outval_reg[2:0];
   assign sw_next[3] = ctrl_wdog_reg ? wd_out_reg : (outdir_reg[3] & outval_reg[3]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_reg <= '0;
         irq <= 1'b0;
         switch_closed <= 4'h0;
         led_buf_full <= 1'b0;
      end else begin
         istat_reg <= (istat_reg & ~(wr_iclr ? wdata_reg[NIRQ-1:0] : '0)) | ev_set;
         irq <= |(istat_reg & ien_reg);
         switch_closed <= sw_next;
         led_buf_full <= buf_full;
      end
   end

   assign rd_hit = s_axi_araddr <= A_IEN && s_axi_araddr[1:0] == 2'h0;
   always_comb begin
      case (s_axi_araddr)
         A_CTRL: rd_mux = {31'h0, ctrl_wdog_reg};
         A_OUTDIR: rd_mux = {28'h0, outdir_reg};
         A_OUTVAL: rd_mux = {28'h0, outval_reg};
         A_RISE: rd_mux = rise_en_reg;
         A_FALL: rd_mux = fall_en_reg;
         A_LEVEL: rd_mux = level;
         A_COUNT: rd_mux = {24'h0, count_reg};
         A_LOST: rd_mux = {16'h0, lost_reg};
         A_EVTIME: rd_mux = mif.rdata[TS_W-1:0];
         A_EVINFO: rd_mux = {26'h0, mif.rdata[DW-1 -: 6]};
         A_POP: rd_mux = mif.rdata[2*TS_W-1:TS_W];
         A_DATE: rd_mux = date_reg;
         A_TIME: rd_mux = time_reg;
         A_ISTAT: rd_mux = {29'h0, istat_reg};
         A_IEN: rd_mux = {29'h0, ien_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // ecw_top
`default_nettype wire
